// >>> dv/pcs_config_props.sv
// Purpose: port-level checker for pcs_config_bank
// Assumes: one clock, asynchronous active-low reset, master-capable build
// Notes: the system error enable is not visible, so system error is tied to parity_report_ena
`timescale 1ns/1ps
`default_nettype none
module pcs_config_props (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // observed ports
  input wire pcs_pkg::pcs_bus_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire pcs_pkg::pcs_core_evt_s core_evt,
  input wire logic master_start,
  input wire logic [5:0] local_status,
  input wire logic [7:0] line_size_out,
  input wire logic tenure_active,
  input wire logic tenure_expired,
  input wire logic parity_report_ena,
  input wire logic sys_err_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic clr15;
  // a write of one to the parity flag; a set in the same cycle wins
  assign clr15 = reg_req.wr && reg_req.addr == pcs_pkg::REG_STATUS && reg_req.wdata[15];
  a_parity_sets: assert property (core_evt.addr_parity_err || core_evt.data_parity_err |=> local_status[5])
    else $error("parity flag not set");
  a_tabort_rcv: assert property (core_evt.master_tabort_seen |=> local_status[2])
    else $error("received target abort flag not set");
  a_mabort_set: assert property (core_evt.master_abort_done |=> local_status[3])
    else $error("master abort flag not set");
  a_serr_cause: assert property (!sys_err_oe_n |-> local_status[4] && $past(core_evt.addr_parity_err && parity_report_ena))
    else $error("system error without cause");
  a_serr_pulse: assert property (!sys_err_oe_n |=> sys_err_oe_n)
    else $error("system error drive too long");
  a_flag_sticky: assert property (local_status[5] && !clr15 |=> local_status[5])
    else $error("parity flag lost");
  a_clear_one: assert property (clr15 && !core_evt.addr_parity_err && !core_evt.data_parity_err |=> !local_status[5])
    else $error("parity flag not cleared");
  a_line_mirror: assert property (reg_req.wr && reg_req.addr == pcs_pkg::REG_LINE_SIZE |=> line_size_out == $past(reg_req.wdata[7:0]))
    else $error("line size not driven out");
  a_tenure_load: assert property (master_start |=> tenure_active)
    else $error("tenure count not started");
  a_expire_after: assert property ($rose(tenure_expired) |-> $past(tenure_active) && !tenure_active)
    else $error("tenure expiry out of order");
  c_serr: cover property (!sys_err_oe_n);
  c_expire: cover property ($rose(tenure_expired));
  c_read: cover property (reg_req.rd ##1 reg_rdata != 32'h0);
endmodule
bind pcs_config_bank pcs_config_props i_pcs_config_props (.clk, .resetn, .reg_req, .reg_rdata, .core_evt,
  .master_start, .local_status, .line_size_out, .tenure_active, .tenure_expired, .parity_report_ena, .sys_err_oe_n);
`default_nettype wire

// >>> dv/pcs_far_model.sv
// Purpose: far side of the bank: bus engine pulses and local master logic
// Assumes: bench commands arrive on clk
// Notes: every command is registered once, so events are clean one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module pcs_far_model (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bench commands
  input wire logic [6:0] cmd,
  input wire logic abort_req,
  input wire logic [7:0] line_size_out,
  // toward the bank
  output var pcs_pkg::pcs_core_evt_s core_evt,
  output logic master_start,
  output logic master_done,
  output logic local_abort_request_n,
  output logic [7:0] burst_dwords
);
  // events and master strobes, one cycle each
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {master_start, master_done, core_evt} <= 7'h00;
      local_abort_request_n <= 1'b1;
    end else begin
      {master_start, master_done, core_evt} <= cmd;
      local_abort_request_n <= !abort_req;
    end
  end
  // line burst sizing
  // sampled at start so a rewrite mid-burst cannot change its length
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) burst_dwords <= 8'h00;
    else if (cmd[6]) burst_dwords <= line_size_out;
  end
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Purpose: self-checking bench for pcs_config_bank
// Assumes: default build, far-side model makes the event pulses
// Notes: read answers are queued and compared by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  pcs_pkg::pcs_bus_req_s reg_req = '0;
  pcs_pkg::pcs_core_evt_s core_evt;
  logic [31:0] reg_rdata;
  logic [6:0] cmd = 7'h00;
  logic abort_req = 1'b0;
  logic master_start, master_done, local_abort_request_n;
  logic [5:0] local_status;
  logic [7:0] line_size_out, v, burst;
  logic tenure_active, tenure_expired, parity_report_ena, sys_err_out, sys_err_oe_n, irq;
  logic [31:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [15:0] sts = 16'h0400;
  logic [4:0] ifl = 5'h00;
  logic [1:0] ctrl = 2'h0;
  int seed = 32'hDC8B;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  pcs_config_bank i_pcs_config_bank (.clk, .resetn, .reg_req, .reg_rdata, .core_evt, .master_start,
    .master_done, .local_abort_request_n, .local_status, .line_size_out, .tenure_active, .tenure_expired,
    .parity_report_ena, .sys_err_out, .sys_err_oe_n, .irq);
  pcs_far_model i_pcs_far_model (.clk, .resetn, .cmd, .abort_req, .line_size_out, .core_evt, .master_start,
    .master_done, .local_abort_request_n, .burst_dwords(burst));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one bus cycle; strobes stay up until the next call or idle
  task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w);
    reg_req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    bus(a, 32'h0, 1'b0);
  endtask
  task automatic idle();
    reg_req <= '0;
    @(posedge clk);
    @(posedge clk);
  endtask
  // pulse one far-side command, then check what it left at the ports
  task automatic ev(input int k);
    logic [15:0] nb;
    nb = 16'h0000;
    if (k < 2) nb[15] = 1'b1;
    else if (k < 4 || (k == 4 && abort_req)) nb[15-k] = 1'b1;
    if (k == 1 && ctrl == 2'h3) nb[14] = 1'b1;
    sts = sts | nb;
    ifl = ifl | nb[15:11];
    cmd <= 7'(1 << k);
    @(posedge clk);
    cmd <= 7'h00;
    @(posedge clk);
    #1;
    chk("serr_oe_n", sys_err_oe_n, 32'(!nb[14]));
    chk("local_status", local_status, {sts[15:11], 1'b0});
    chk("serr_out", sys_err_out, 32'h0);
    @(posedge clk);
  endtask
  // read monitor: oldest note against the answer of the cycle after rd
  always @(posedge clk) begin
    rd_d <= reg_req.rd;
    if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
  end
  // hang guard, far above the fewer than one hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    // outputs under reset: nothing flagged, pin released, line size zero
    chk("rst_status", local_status, 32'h0);
    chk("rst_serr_oe_n", sys_err_oe_n, 32'h1);
    chk("rst_line_size", line_size_out, 32'h0);
    resetn <= 1'b1;
    @(posedge clk);
    rd(pcs_pkg::REG_STATUS, 32'h400);
    rd(pcs_pkg::REG_REVISION, 32'(pcs_pkg::REVISION_DEFAULT));
    rd(pcs_pkg::REG_CLASS, 32'hFF0000);
    rd(pcs_pkg::REG_TENURE, 32'h0);
    bus(pcs_pkg::REG_CLASS, 32'h0, 1'b1);
    bus(pcs_pkg::REG_REVISION, 32'hFF, 1'b1);
    bus(4'hA, 32'h1, 1'b1);
    rd(4'hA, 32'h0);
    rd(pcs_pkg::REG_CLASS, 32'hFF0000);
    rd(pcs_pkg::REG_REVISION, 32'(pcs_pkg::REVISION_DEFAULT));
    bus(pcs_pkg::REG_TENURE, 32'hFF, 1'b1);
    rd(pcs_pkg::REG_TENURE, 32'hF8);
    // random line sizes reach the local side
    repeat (4) begin
      v = 8'($random(seed));
      bus(pcs_pkg::REG_LINE_SIZE, 32'(v), 1'b1);
      rd(pcs_pkg::REG_LINE_SIZE, 32'(v));
      chk("line_size", line_size_out, 32'(v));
    end
    // tenure of eight: nine counting cycles, then expiry
    bus(pcs_pkg::REG_TENURE, 32'h8, 1'b1);
    idle();
    cmd <= 7'h40;
    @(posedge clk);
    cmd <= 7'h00;
    @(posedge clk);
    repeat (8) @(posedge clk);
    #1;
    chk("active", tenure_active, 32'h1);
    chk("expired", tenure_expired, 32'h0);
    @(posedge clk);
    #1;
    chk("expired", tenure_expired, 32'h1);
    @(posedge clk);
    ev(5);
    chk("expired", tenure_expired, 32'h0);
    chk("burst", burst, 32'(v));
    // target abort with no local request leaves bit 11 clear
    ev(4);
    // every event with enables off, irq unmasked
    abort_req <= 1'b1;
    bus(pcs_pkg::REG_IRQ_MASK, 32'h1F, 1'b1);
    idle();
    for (int k = 0; k < 5; k++) ev(k);
    chk("irq", irq, 32'h1);
    rd(pcs_pkg::REG_IRQ_STATUS, 32'(ifl));
    ifl = 5'h00;
    rd(pcs_pkg::REG_STATUS, 32'(sts));
    bus(pcs_pkg::REG_STATUS, 32'hF800, 1'b1);
    sts = 16'h0400;
    rd(pcs_pkg::REG_STATUS, 32'(sts));
    bus(pcs_pkg::REG_CONTROL, 32'h3, 1'b1);
    idle();
    chk("irq", irq, 32'h0);
    ctrl = 2'h3;
    chk("perr_ena", parity_report_ena, 32'h1);
    ev(1);
    bus(pcs_pkg::REG_STATUS, 32'h4000, 1'b1);
    sts[14] = 1'b0;
    rd(pcs_pkg::REG_STATUS, 32'(sts));
    bus(pcs_pkg::REG_CONTROL, 32'h1, 1'b1);
    bus(pcs_pkg::REG_IRQ_MASK, 32'h0, 1'b1);
    rd(pcs_pkg::REG_IRQ_STATUS, 32'(ifl));
    ifl = 5'h00;
    idle();
    // parity enable alone must not signal system error; masked event stays quiet
    ctrl = 2'h1;
    ev(1);
    chk("irq", irq, 32'h0);
    rd(pcs_pkg::REG_STATUS, 32'(sts));
    idle();
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> rtl/pcs_config_bank.sv
// Purpose: upper status flags, identity, line size and tenure limit of a bus function
// Assumes: register port and event pulses are on clk; local side is on clk too
// Notes: target-only builds drop line size and tenure limit, reading them as zero
`timescale 1ns/1ps
`default_nettype none
module pcs_config_bank #(
  parameter bit MASTER_CAPABLE = 1'b1,
  parameter logic [7:0] REVISION_ID = pcs_pkg::REVISION_DEFAULT,
  parameter logic [23:0] CLASS_CODE = pcs_pkg::CLASS_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire pcs_pkg::pcs_bus_req_s reg_req,
  output logic [31:0] reg_rdata,
  // bus engine events
  input wire pcs_pkg::pcs_core_evt_s core_evt,
  input wire logic master_start,
  input wire logic master_done,
  // local side
  input wire logic local_abort_request_n,
  output logic [5:0] local_status,
  output logic [7:0] line_size_out,
  output logic tenure_active,
  output logic tenure_expired,
  output logic parity_report_ena,
  // system error pin, drive only
  output logic sys_err_out,
  output logic sys_err_oe_n,
  // interrupt
  output logic irq
);

  // a forced unknown build switch would leave line size and tenure half built
  if (MASTER_CAPABLE !== 1'b0 && MASTER_CAPABLE !== 1'b1) begin : g_chk
    $error("pcs_config_bank MASTER_CAPABLE must be 0 or 1");
  end

  // the sticky banks are sized by the event count, which must span the status field
  if (pcs_pkg::NUM_EVENTS != pcs_pkg::STAT_EVT_MSB - pcs_pkg::STAT_EVT_LSB + 1) begin : g_evt_chk
    $error("pcs_config_bank event count does not match the status field");
  end

  // the low three tenure bits are tied low; a mask that opened them breaks that
  if (pcs_pkg::TENURE_WR_MASK[2:0] != 3'h0) begin : g_mask_chk
    $error("pcs_config_bank tenure write mask must keep bits 2 to 0 closed");
  end

  // register selection shared by read and write paths
  function automatic logic pcs_sel(input logic [3:0] addr, input logic [3:0] idx);
    return addr == idx;
  endfunction

  // widen a narrow field into the 32-bit read word
  function automatic logic [31:0] pcs_word(input logic [23:0] v);
    return {8'h00, v};
  endfunction

  logic [1:0] ctrl_reg;
  logic [7:0] line_size_reg;
  logic [7:0] tenure_reg;
  logic [4:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  logic abort_req_seen_reg;
  logic serr_drive_reg;
  logic [4:0] status_flags;
  logic [4:0] irq_flags;
  logic [4:0] status_clr;
  logic [4:0] irq_clr;
  logic [15:0] status_word;
  logic [31:0] rdata_next;
  logic wr_status;
  logic wr_line;
  logic wr_tenure;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_irq;
  logic perr_ena;
  logic serr_ena;
  logic serr_fire;
  pcs_pkg::pcs_event_s evt;

  // write and read decode
  assign wr_status = reg_req.wr && pcs_sel(reg_req.addr, pcs_pkg::REG_STATUS);
  assign wr_line = reg_req.wr && pcs_sel(reg_req.addr, pcs_pkg::REG_LINE_SIZE);
  assign wr_tenure = reg_req.wr && pcs_sel(reg_req.addr, pcs_pkg::REG_TENURE);
  assign wr_ctrl = reg_req.wr && pcs_sel(reg_req.addr, pcs_pkg::REG_CONTROL);
  assign wr_mask = reg_req.wr && pcs_sel(reg_req.addr, pcs_pkg::REG_IRQ_MASK);
  assign rd_irq = reg_req.rd && pcs_sel(reg_req.addr, pcs_pkg::REG_IRQ_STATUS);

  assign perr_ena = ctrl_reg[pcs_pkg::CTRL_PERR_ENA];
  assign serr_ena = ctrl_reg[pcs_pkg::CTRL_SERR_ENA];

  // control enables, software owned
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= pcs_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= reg_req.wdata[1:0];
    end
  end

  // local abort request may lead the abort itself by several cycles
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      abort_req_seen_reg <= 1'b0;
    end else if (!local_abort_request_n) begin
      abort_req_seen_reg <= 1'b1;
    end else if (core_evt.target_abort_issued) begin
      abort_req_seen_reg <= 1'b0;
    end
  end

  // address parity gated by both the system error enable and the parity enable
  assign serr_fire = core_evt.addr_parity_err && serr_ena && perr_ena;

  // event mapping onto the sticky bank
  always_comb begin
    evt.tabort_sig = core_evt.target_abort_issued && (!local_abort_request_n || abort_req_seen_reg);
    evt.tabort_rcv = core_evt.master_tabort_seen;
    evt.master_abort = core_evt.master_abort_done;
    evt.sys_err = serr_fire;
    evt.parity_err = core_evt.addr_parity_err || core_evt.data_parity_err;
  end

  // one-cycle drive of the system error pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serr_drive_reg <= 1'b0;
    end else begin
      serr_drive_reg <= serr_fire;
    end
  end

  // open-drain style: the pin value never moves, only its enable does
  assign sys_err_out = 1'b0;
  assign sys_err_oe_n = ~serr_drive_reg;

  assign status_clr = wr_status ? reg_req.wdata[pcs_pkg::STAT_EVT_MSB:pcs_pkg::STAT_EVT_LSB] : 5'h00;

  // software-visible copy, cleared only by a write of one
  // flags hold until cleared by software
  pcs_sticky_bank #(
    .W(pcs_pkg::NUM_EVENTS)
  ) u_status (
    .clk(clk),
    .resetn(resetn),
    .set(evt),
    .clr(status_clr),
    .flags(status_flags)
  );

  // bits 10 and 9 carry the fixed slow select timing, the rest stay zero
  // fixed timing bits give the reset value
  assign status_word = pcs_pkg::STATUS_FIXED | {status_flags, 11'h000};

  // mirror bits 1 to 5, bit 0 belongs elsewhere
  assign local_status = {status_flags, 1'b0};

  // interrupt flags clear on read of their register
  assign irq_clr = rd_irq ? 5'h1F : 5'h00;

  // second copy, so reading interrupt flags leaves the status word alone
  pcs_sticky_bank #(
    .W(pcs_pkg::NUM_EVENTS)
  ) u_irq (
    .clk(clk),
    .resetn(resetn),
    .set(evt),
    .clr(irq_clr),
    .flags(irq_flags)
  );

  // interrupt mask, one means enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_reg <= pcs_pkg::IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_req.wdata[4:0];
    end
  end

  // level output; a masked flag keeps latching and raises irq once unmasked
  assign irq = |(irq_flags & irq_mask_reg);

  // target-only builds keep the reset zero, so the word reads zero
  // line size held for the local master
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      line_size_reg <= pcs_pkg::LINE_SIZE_RESET;
    end else if (wr_line && MASTER_CAPABLE) begin
      line_size_reg <= reg_req.wdata[7:0];
    end
  end

  // local master relies on this value
  assign line_size_out = line_size_reg;

  // only bits 7 to 3 take writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tenure_reg <= pcs_pkg::TENURE_RESET;
    end else if (wr_tenure && MASTER_CAPABLE) begin
      tenure_reg <= reg_req.wdata[7:0] & pcs_pkg::TENURE_WR_MASK;
    end
  end

  pcs_tenure_counter #(
    .W(8)
  ) u_tenure (
    .clk(clk),
    .resetn(resetn),
    .enable(MASTER_CAPABLE),
    .start(master_start),
    .done(master_done),
    .load_value(tenure_reg),
    .count(),
    .active(tenure_active),
    .expired(tenure_expired)
  );

  // the bus engine gates its own parity reporting on this enable
  assign parity_report_ena = perr_ena;

  // read mux; unmapped words read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_req.addr)
      pcs_pkg::REG_STATUS: begin
        rdata_next = pcs_word({8'h00, status_word});
      end
      pcs_pkg::REG_REVISION: begin
        rdata_next = pcs_word({16'h0000, REVISION_ID});
      end
      pcs_pkg::REG_CLASS: begin
        rdata_next = pcs_word(CLASS_CODE);
      end
      pcs_pkg::REG_LINE_SIZE: begin
        rdata_next = pcs_word({16'h0000, line_size_reg});
      end
      pcs_pkg::REG_TENURE: begin
        rdata_next = pcs_word({16'h0000, tenure_reg});
      end
      pcs_pkg::REG_CONTROL: begin
        rdata_next = pcs_word({22'h0, ctrl_reg});
      end
      pcs_pkg::REG_IRQ_STATUS: begin
        rdata_next = pcs_word({19'h0, irq_flags});
      end
      pcs_pkg::REG_IRQ_MASK: begin
        rdata_next = pcs_word({19'h0, irq_mask_reg});
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= reg_req.rd ? rdata_next : 32'h0000_0000;
    end
  end

  // zero outside the answer cycle keeps an or-combined read bus quiet
  assign reg_rdata = rdata_reg;

endmodule
`default_nettype wire

// >>> rtl/pcs_pkg.sv
// Purpose: shared constants, register map and carriers for the config status and timer bank
// Assumes: one 200 MHz clock, word-indexed register port
// Notes: field positions follow the configuration header layout
package pcs_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // register indices on the plain register port
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_REVISION = 4'h1;
  localparam logic [3:0] REG_CLASS = 4'h2;
  localparam logic [3:0] REG_LINE_SIZE = 4'h3;
  localparam logic [3:0] REG_TENURE = 4'h4;
  localparam logic [3:0] REG_CONTROL = 4'h5;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK = 4'h7;

  // status word layout
  localparam int NUM_EVENTS = 5;
  localparam int STAT_EVT_LSB = 11;
  localparam int STAT_EVT_MSB = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0400;
  localparam logic [15:0] STATUS_FIXED = 16'h0400;

  // control word layout
  localparam int CTRL_PERR_ENA = 0;
  localparam int CTRL_SERR_ENA = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // identification, line size and tenure limit
  localparam logic [7:0] REVISION_DEFAULT = 8'h01; // arbitrary value
  localparam logic [23:0] CLASS_DEFAULT = 24'hFF0000;
  localparam logic [7:0] LINE_SIZE_RESET = 8'h00;
  localparam logic [7:0] TENURE_RESET = 8'h00;
  localparam logic [7:0] TENURE_WR_MASK = 8'hF8;
  localparam logic [4:0] IRQ_MASK_RESET = 5'h00;

  // sticky events, bit i lands on status bit 11+i and local status bit 1+i
  typedef struct packed {
    logic parity_err;
    logic sys_err;
    logic master_abort;
    logic tabort_rcv;
    logic tabort_sig;
  } pcs_event_s;

  // raw happenings reported by the bus engine, one-cycle pulses
  typedef struct packed {
    logic target_abort_issued;
    logic master_tabort_seen;
    logic master_abort_done;
    logic addr_parity_err;
    logic data_parity_err;
  } pcs_core_evt_s;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcs_bus_req_s;

  // tenure counter states
  typedef enum logic [1:0] {
    TEN_IDLE,
    TEN_COUNT,
    TEN_EXPIRED
  } pcs_tenure_e;

endpackage

// >>> rtl/pcs_sticky_bank.sv
// Purpose: bank of sticky flags with a per-bit clear
// Assumes: set and clear come from logic on clk
// Notes: a set in the clearing cycle survives
`timescale 1ns/1ps
`default_nettype none
module pcs_sticky_bank #(
  parameter int W = 5
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // flag control
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // flag state
  output logic [W-1:0] flags
);

  if (W < 1) begin : g_chk
    $error("pcs_sticky_bank needs W of at least 1");
  end

  logic [W-1:0] flags_reg;

  // set beats clear so no event is lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= (flags_reg & ~clr) | set;
    end
  end

  assign flags = flags_reg;

endmodule
`default_nettype wire

// >>> rtl/pcs_tenure_counter.sv
// Purpose: master bus tenure countdown
// Assumes: start and done are one-cycle pulses on clk
// Notes: a loaded value of zero expires on the next edge
`timescale 1ns/1ps
`default_nettype none
module pcs_tenure_counter #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic enable,
  input wire logic start,
  input wire logic done,
  input wire logic [W-1:0] load_value,
  // state
  output logic [W-1:0] count,
  output logic active,
  output logic expired
);

  if (W < 1) begin : g_chk
    $error("pcs_tenure_counter needs W of at least 1");
  end

  pcs_pkg::pcs_tenure_e state_reg;
  logic [W-1:0] count_reg;

  // load and expire, one step per edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= pcs_pkg::TEN_IDLE;
      count_reg <= '0;
    end else if (!enable) begin
      state_reg <= pcs_pkg::TEN_IDLE;
      count_reg <= '0;
    end else if (start) begin
      state_reg <= pcs_pkg::TEN_COUNT;
      count_reg <= load_value;
    end else begin
      unique case (state_reg)
        pcs_pkg::TEN_IDLE: begin
          count_reg <= count_reg;
        end
        pcs_pkg::TEN_COUNT: begin
          if (done) begin
            state_reg <= pcs_pkg::TEN_IDLE;
          end else if (count_reg == '0) begin
            state_reg <= pcs_pkg::TEN_EXPIRED;
          end else begin
            count_reg <= count_reg - 1'b1;
          end
        end
        pcs_pkg::TEN_EXPIRED: begin
          if (done) begin
            state_reg <= pcs_pkg::TEN_IDLE;
          end
        end
        default: begin
          state_reg <= pcs_pkg::TEN_IDLE;
        end
      endcase
    end
  end

  assign count = count_reg;
  assign active = (state_reg == pcs_pkg::TEN_COUNT);
  assign expired = (state_reg == pcs_pkg::TEN_EXPIRED);

endmodule
`default_nettype wire
